// file: design/tcp_pkg.sv
// constants, register map and shared types of the timer/counter with prescaler
package tcp_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;

   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_TMR = 10'h001;
   localparam logic [9:0] IDX_IRQCTL = 10'h00B;
   localparam logic [9:0] IDX_IRQCTL_ALT = 10'h08B;
   localparam logic [9:0] IDX_OPTION = 10'h081;
   localparam logic [9:0] IDX_CTRL = 10'h020;

   // interrupt_control bit positions
   localparam int BIT_GLOBAL_EN = 7;
   localparam int BIT_PERIPH_EN = 6;
   localparam int BIT_OVF_EN = 5;
   localparam int BIT_PIN_EN = 4;
   localparam int BIT_PORT_EN = 3;
   localparam int BIT_OVF_FLAG = 2;
   localparam int BIT_PIN_FLAG = 1;
   localparam int BIT_PORT_FLAG = 0;

   // control register bit positions
   localparam int CTRL_HALT = 0;
   localparam int CTRL_WDCLR = 1;

   localparam logic [7:0] IRQCTL_RST = 8'h00;
   localparam logic [7:0] OPTION_RST = 8'h00;
   localparam logic [7:0] TMR_RST = 8'h00;
   localparam logic [7:0] TMR_MAX = 8'hFF;
   localparam logic [1:0] WRITE_INHIBIT = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum {SEL_NONE, SEL_TMR, SEL_IRQCTL, SEL_OPTION, SEL_CTRL} tcp_sel_t;

   typedef struct packed {
      logic [1:0] spare;
      logic clock_source;
      logic edge_select;
      logic assignment;
      logic [2:0] ratio;
   } tcp_option_t;
endpackage : tcp_pkg

// file: design/tcp_sync.sv
// three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module tcp_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin,
   output logic rise,
   output logic fall
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } tcp_sync_state_t;

   tcp_sync_state_t q;
   tcp_sync_state_t next_q;

   always_comb begin
      next_q = q;
      next_q.s1 = pin;
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
      // a change counts only once stages two and three agree
      if (q.s2 == q.s3) begin
         next_q.level = q.s3;
      end
   end

   assign rise = (q.s2 == q.s3) && q.s3 && !q.level;
   assign fall = (q.s2 == q.s3) && !q.s3 && q.level;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
endmodule : tcp_sync
`default_nettype wire

// file: design/tcp_prescale.sv
// shared 8-bit prescaler / postscaler counter
`timescale 1ns/1ps
`default_nettype none
module tcp_prescale #(
   parameter int W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic evt,
   input wire logic clr,
   input wire logic [2:0] ratio,
   output logic tick
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } tcp_presc_state_t;

   tcp_presc_state_t q;
   tcp_presc_state_t next_q;

   // ratio n divides by two to the n plus one
   function automatic logic [W-1:0] ratio_mask(input logic [2:0] n);
      logic [W:0] m;
      // shift amount widened so ratio 7 reaches 1:256 instead of wrapping
      m = ({{W{1'b0}}, 1'b1} << ({1'b0, n} + 4'h1)) - {{W{1'b0}}, 1'b1};
      return m[W-1:0];
   endfunction : ratio_mask

   // [R19] terminal count per ratio
   assign tick = evt && !clr && ((q.cnt & ratio_mask(ratio)) == ratio_mask(ratio));

   always_comb begin
      next_q = q;
      // [R10] clear beats any event
      if (clr) begin
         next_q.cnt = '0;
      end else if (evt) begin
         next_q.cnt = q.cnt + {{(W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   property p_clear_zero;
      @(posedge aclk) disable iff (!aresetn)
      clr |=> (q.cnt == '0);
   endproperty
   a_clear_zero: assert property (p_clear_zero) else $error("prescaler not cleared"); // [R11]
endmodule : tcp_prescale
`default_nettype wire

// file: design/tcp_timer.sv
// timer/counter with shared prescaler and overflow interrupt, AXI4-Lite slave
// Summary of operation
// [R1] clock source bit clear: count advances every cycle without prescaler
// [R2] after a count write, two cycles pass with no increment
// [R3] clock source bit set: count advances on chosen external pin edge
// [R4] edge select clear picks rising, set picks falling edge
// [R5] assignment bit clear gives prescaler to timer, set to watchdog
// [R6] prescaler counter has no software read or write access
// [R7] timer prescale ratios 1:2 to 1:256 in powers of two
// [R8] prescaler is one 8-bit counter, pre for timer, post for watchdog
// [R9] only one user of prescaler; the other runs undivided
// [R10] writing the count clears prescaler while timer owns it
// [R11] watchdog clear command clears prescaler while watchdog owns it
// [R12] rollover from FF to 00 sets overflow flag
// [R13] overflow interrupt masked while its enable is clear
// [R14] software clears overflow flag; hardware never does
// [R15] timer stops during halt, so it cannot wake the core
// [R16] flags set regardless of local or global enables
// [R17] global enable bit 7 gates every interrupt
// [R18] interrupt control reachable at both bank addresses, one storage
// [R19] ratio field n divides by two to the n plus one
// [R20] external pin synchronised before it advances the count
// [R21] request raised only when flag, local and global enables set
`timescale 1ns/1ps
`default_nettype none
module tcp_timer
   import tcp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic external_count_clock_pin,
   input wire logic watchdog_tick_in,
   output logic watchdog_tick_out,
   output logic irq_request
);
   typedef struct packed {
      logic [REG_W-1:0] tmr;
      logic [1:0] inhibit;
      logic [REG_W-1:0] irqctl;
      tcp_option_t option;
      logic halt;
      logic irq;
      logic wdog_out;
      logic aw_hold;
      logic [ADDR_W-1:0] aw_addr;
      logic w_hold;
      logic [REG_W-1:0] w_data;
      logic w_strb0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } tcp_state_t;

   tcp_state_t q;
   tcp_state_t next_q;

   // [R18] both bank indices select the same storage
   function automatic tcp_sel_t decode(input logic [ADDR_W-1:0] a);
      tcp_sel_t s;
      s = SEL_NONE;
      if (a[1:0] == 2'h0) begin
         if (a[11:2] == IDX_TMR) begin
            s = SEL_TMR;
         end else if (a[11:2] == IDX_IRQCTL || a[11:2] == IDX_IRQCTL_ALT) begin
            s = SEL_IRQCTL;
         end else if (a[11:2] == IDX_OPTION) begin
            s = SEL_OPTION;
         end else if (a[11:2] == IDX_CTRL) begin
            s = SEL_CTRL;
         end
      end
      return s;
   endfunction : decode

   logic ext_rise;
   logic ext_fall;
   logic presc_tick;
   logic presc_evt;
   logic presc_clr;
   tcp_sel_t wsel;
   tcp_sel_t rsel;
   logic commit;
   logic tmr_wr;
   logic irqctl_wr;
   logic wd_clear;
   logic ext_evt;
   logic src_evt;
   logic gated_evt;
   logic inc;
   logic [REG_W-1:0] rval;

   // [R20] pin passes the three-stage filter first
   tcp_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(external_count_clock_pin),
      .rise(ext_rise),
      .fall(ext_fall)
   );

   // [R8] one counter serves both users
   tcp_prescale #(.W(REG_W)) u_presc (
      .aclk(aclk),
      .aresetn(aresetn),
      .evt(presc_evt),
      .clr(presc_clr),
      .ratio(q.option.ratio),
      .tick(presc_tick)
   );

   assign wsel = decode(q.aw_addr);
   assign rsel = decode(s_axi_araddr);
   assign commit = q.aw_hold && q.w_hold && !q.bvalid && q.w_strb0;
   assign tmr_wr = commit && (wsel == SEL_TMR);
   assign irqctl_wr = commit && (wsel == SEL_IRQCTL);
   assign wd_clear = commit && (wsel == SEL_CTRL) && q.w_data[CTRL_WDCLR];

   // [R4] edge choice
   assign ext_evt = q.option.edge_select ? ext_fall : ext_rise;
   // [R1] [R3] internal source ticks every instruction cycle
   assign src_evt = q.option.clock_source ? ext_evt : 1'b1;
   // [R15] [R2] halt and post-write window freeze counting
   assign gated_evt = src_evt && !q.halt && (q.inhibit == 2'h0) && !tmr_wr;
   // [R5] [R9] steer the prescaler to one user only
   assign presc_evt = q.option.assignment ? watchdog_tick_in : gated_evt;
   // [R10] [R11] clear source follows the owner
   assign presc_clr = q.option.assignment ? wd_clear : tmr_wr;
   // [R7] divided count when timer owns prescaler
   assign inc = q.option.assignment ? gated_evt : (presc_tick && !tmr_wr);

   // [R6] prescaler count is never readable
   always_comb begin
      rval = '0;
      unique case (rsel)
         SEL_TMR: rval = q.tmr;
         SEL_IRQCTL: rval = q.irqctl;
         SEL_OPTION: rval = q.option;
         SEL_CTRL: rval = {{(REG_W-1){1'b0}}, q.halt};
         SEL_NONE: rval = '0;
      endcase
   end

   always_comb begin
      next_q = q;
      // read channel
      if (q.rvalid && s_axi_rready) begin
         next_q.rvalid = 1'b0;
      end
      if (q.arready && s_axi_arvalid) begin
         next_q.rvalid = 1'b1;
         next_q.rdata = {{(DATA_W-REG_W){1'b0}}, rval};
         next_q.rresp = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      // write channel; address and data taken in either order
      if (q.bvalid && s_axi_bready) begin
         next_q.bvalid = 1'b0;
      end
      if (q.awready && s_axi_awvalid) begin
         next_q.aw_hold = 1'b1;
         next_q.aw_addr = s_axi_awaddr;
      end
      if (q.wready && s_axi_wvalid) begin
         next_q.w_hold = 1'b1;
         next_q.w_data = s_axi_wdata[REG_W-1:0];
         next_q.w_strb0 = s_axi_wstrb[0];
      end
      if (q.aw_hold && q.w_hold && !q.bvalid) begin
         next_q.aw_hold = 1'b0;
         next_q.w_hold = 1'b0;
         next_q.bvalid = 1'b1;
         next_q.bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         if (q.w_strb0 && wsel == SEL_OPTION) begin
            next_q.option = q.w_data;
         end
         if (q.w_strb0 && wsel == SEL_CTRL) begin
            next_q.halt = q.w_data[CTRL_HALT];
         end
      end
      next_q.awready = !next_q.aw_hold && !next_q.bvalid;
      next_q.wready = !next_q.w_hold && !next_q.bvalid;
      next_q.arready = !next_q.rvalid;

      // count register
      if (q.inhibit != 2'h0) begin
         next_q.inhibit = q.inhibit - 2'h1;
      end
      // [R2] write loads value and opens a two-cycle hold-off
      if (tmr_wr) begin
         next_q.tmr = q.w_data;
         next_q.inhibit = WRITE_INHIBIT;
      end else if (inc) begin
         next_q.tmr = q.tmr + 8'h01;
      end

      // [R14] flag only cleared by a software write
      if (irqctl_wr) begin
         next_q.irqctl = q.w_data;
      end
      // [R12] [R16] rollover sets flag, set wins over clear
      if (inc && q.tmr == TMR_MAX) begin
         next_q.irqctl[BIT_OVF_FLAG] = 1'b1;
      end
      // [R21] [R13] [R17] request needs flag and both enables
      next_q.irq = q.irqctl[BIT_GLOBAL_EN] && q.irqctl[BIT_OVF_EN] && q.irqctl[BIT_OVF_FLAG];
      // [R9] watchdog gets raw tick unless it owns the prescaler
      next_q.wdog_out = q.option.assignment ? presc_tick : watchdog_tick_in;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.tmr <= TMR_RST;
         q.irqctl <= IRQCTL_RST;
         q.option <= OPTION_RST;
      end else begin
         q <= next_q;
      end
   end

   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign irq_request = q.irq;
   assign watchdog_tick_out = q.wdog_out;

   property p_write_holdoff;
      @(posedge aclk) disable iff (!aresetn)
      tmr_wr ##1 (!tmr_wr)[*2] |-> ##1 (q.tmr == $past(q.tmr, 2));
   endproperty
   a_write_holdoff: assert property (p_write_holdoff) else $error("count moved in hold-off"); // [R2]

   property p_timer_mode;
      @(posedge aclk) disable iff (!aresetn)
      (!q.option.clock_source && q.option.assignment && !q.halt && q.inhibit == 2'h0 && !tmr_wr)
         |=> (q.tmr == $past(q.tmr) + 8'h01);
   endproperty
   a_timer_mode: assert property (p_timer_mode) else $error("timer did not advance"); // [R1]

   property p_overflow_flag;
      @(posedge aclk) disable iff (!aresetn)
      (inc && q.tmr == TMR_MAX) |=> (q.irqctl[BIT_OVF_FLAG] && q.tmr == 8'h00);
   endproperty
   a_overflow_flag: assert property (p_overflow_flag) else $error("overflow flag not set"); // [R12]

   property p_halt_stops;
      @(posedge aclk) disable iff (!aresetn)
      (q.halt && !tmr_wr) |=> $stable(q.tmr);
   endproperty
   a_halt_stops: assert property (p_halt_stops) else $error("count moved in halt"); // [R15]

   property p_local_mask;
      @(posedge aclk) disable iff (!aresetn)
      !q.irqctl[BIT_OVF_EN] |=> !irq_request;
   endproperty
   a_local_mask: assert property (p_local_mask) else $error("masked request raised"); // [R13]

   property p_global_mask;
      @(posedge aclk) disable iff (!aresetn)
      !q.irqctl[BIT_GLOBAL_EN] |=> !irq_request;
   endproperty
   a_global_mask: assert property (p_global_mask) else $error("request past global disable"); // [R17]

   property p_request;
      @(posedge aclk) disable iff (!aresetn)
      (q.irqctl[BIT_GLOBAL_EN] && q.irqctl[BIT_OVF_EN] && q.irqctl[BIT_OVF_FLAG]) |=> irq_request;
   endproperty
   a_request: assert property (p_request) else $error("request missing"); // [R21]

   property p_wdog_raw;
      @(posedge aclk) disable iff (!aresetn)
      (!q.option.assignment && watchdog_tick_in) |=> watchdog_tick_out;
   endproperty
   a_wdog_raw: assert property (p_wdog_raw) else $error("watchdog tick lost"); // [R9]

   property p_counter_mode;
      @(posedge aclk) disable iff (!aresetn)
      (q.option.clock_source && q.option.assignment && !ext_evt) |=> $stable(q.tmr) || $past(tmr_wr);
   endproperty
   a_counter_mode: assert property (p_counter_mode) else $error("counted without edge"); // [R3]
endmodule : tcp_timer
`default_nettype wire

// file: tb/tcp_pin_src.sv
// external count pin source model
`timescale 1ns/1ps
`default_nettype none
module tcp_pin_src (
   input wire logic aclk,
   output logic pin
);
   initial begin
      pin = 1'b0;
   end
   // each level held half cycles, pin driven to last and held after a burst
   task automatic drive(input int n, input int half, input logic last);
      for (int i = 0; i < 2 * n; i++) begin
         pin <= ~pin;
         repeat (half) @(posedge aclk);
      end
      pin <= last;
      repeat (half) @(posedge aclk);
   endtask : drive
endmodule : tcp_pin_src
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the timer/counter block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tcp_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
   logic wd_in, wd_out, irq, pin;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   int mismatches, num_checks;
   // one driver only: scenarios take differences against a snapshot
   int wd_outs = 0;
   // strobe and response readies tied: every write is a full word, answers taken at once
   tcp_timer u_tcp_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .external_count_clock_pin(pin),
      .watchdog_tick_in(wd_in), .watchdog_tick_out(wd_out), .irq_request(irq));
   tcp_pin_src u_tcp_pin_src (.aclk(aclk), .pin(pin));
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (wd_out === 1'b1) wd_outs <= wd_outs + 1;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict
   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check_val
   task automatic hang(input string what);
      check_val(what, 32'h1, 32'h0);
      give_verdict();
   endtask : hang
   task automatic axi_write(input logic [11:0] addr, input logic [7:0] data, input logic [1:0] exp);
      bit a = 1'b0, w = 1'b0, done = 1'b0;
      awaddr <= addr;
      wdata <= {24'h0, data};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (int i = 0; i < 40 && !done; i++) begin
         @(posedge aclk);
         if (a && w && bvalid === 1'b1) begin
            done = 1'b1;
            check_val("bresp", {30'h0, exp}, {30'h0, bresp});
         end
         if (!a && awready === 1'b1) begin
            a = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && wready === 1'b1) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      if (!done) hang("write");
   endtask : axi_write
   task automatic axi_read(input logic [11:0] addr, output logic [31:0] data, output logic [1:0] resp);
      bit a = 1'b0, done = 1'b0;
      araddr <= addr;
      arvalid <= 1'b1;
      for (int i = 0; i < 40 && !done; i++) begin
         @(posedge aclk);
         if (a && rvalid === 1'b1) begin
            done = 1'b1;
            data = rdata;
            resp = rresp;
         end
         if (!a && arready === 1'b1) begin
            a = 1'b1;
            arvalid <= 1'b0;
         end
      end
      if (!done) hang("read");
   endtask : axi_read
   task automatic rd_chk(input string what, input logic [11:0] addr, input logic [31:0] exp,
                         input logic [1:0] er = RESP_OKAY);
      logic [31:0] d;
      logic [1:0] r;
      axi_read(addr, d, r);
      check_val(what, exp, d);
      check_val("rresp", {30'h0, er}, {30'h0, r});
   endtask : rd_chk
   task automatic reset_values();
      rd_chk("option", 12'h204, 32'h0);
      rd_chk("irqctl lo", 12'h02C, 32'h0);
      rd_chk("irqctl hi", 12'h22C, 32'h0);
      rd_chk("control", 12'h080, 32'h0);
      check_val("irq", 32'h0, {31'h0, irq});
   endtask : reset_values
   task automatic unmapped();
      rd_chk("unmapped", 12'h300, 32'h0, RESP_SLVERR);
      rd_chk("misaligned", 12'h006, 32'h0, RESP_SLVERR);
      axi_write(12'h300, 8'hFF, RESP_SLVERR);
   endtask : unmapped
   // read spacing is 4*period cycles, so exactly four increments fall between
   task automatic rate_check(input logic [7:0] opt, input int period);
      logic [31:0] a, b;
      logic [1:0] r;
      axi_write(12'h204, opt, RESP_OKAY);
      axi_read(12'h004, a, r);
      repeat (4 * period - 2) @(posedge aclk);
      axi_read(12'h004, b, r);
      check_val("count rate", (a + 32'd4) & 32'hFF, b);
   endtask : rate_check
   task automatic write_holdoff();
      axi_write(12'h204, 8'h08, RESP_OKAY);
      axi_write(12'h004, 8'h5A, RESP_OKAY);
      rd_chk("held count", 12'h004, 32'h5A);
      rd_chk("resumed count", 12'h004, 32'h5B);
   endtask : write_holdoff
   task automatic overflow_irq();
      logic [7:0] vals [4] = '{8'h84, 8'h24, 8'hA4, 8'hA0};
      logic irqs [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
      axi_write(12'h02C, 8'h00, RESP_OKAY);
      axi_write(12'h004, 8'hFE, RESP_OKAY);
      repeat (8) @(posedge aclk);
      axi_write(12'h080, 8'h01, RESP_OKAY);
      rd_chk("flag set", 12'h22C, 32'h04);
      check_val("irq off", 32'h0, {31'h0, irq});
      axi_write(12'h004, 8'h33, RESP_OKAY);
      repeat (20) @(posedge aclk);
      rd_chk("halted count", 12'h004, 32'h33);
      rd_chk("flag kept", 12'h02C, 32'h04);
      for (int i = 0; i < 4; i++) begin
         axi_write(i[0] ? 12'h02C : 12'h22C, vals[i], RESP_OKAY);
         repeat (2) @(posedge aclk);
         check_val("irq", {31'h0, irqs[i]}, {31'h0, irq});
         rd_chk("irqctl", i[0] ? 12'h22C : 12'h02C, {24'h0, vals[i]});
      end
      axi_write(12'h080, 8'h00, RESP_OKAY);
   endtask : overflow_irq
   // six rising and five falling pin edges; asg clear routes them through the 1:2 prescaler
   task automatic ext_count(input logic es, input logic asg, input logic [7:0] exp);
      u_tcp_pin_src.drive(0, 3, 1'b0);
      axi_write(12'h204, {2'b00, 1'b1, es, asg, 3'h0}, RESP_OKAY);
      repeat (8) @(posedge aclk);
      axi_write(12'h004, 8'h00, RESP_OKAY);
      u_tcp_pin_src.drive(5, 3, 1'b1);
      repeat (8) @(posedge aclk);
      rd_chk("ext count", 12'h004, {24'h0, exp});
   endtask : ext_count
   task automatic wd_ticks(input int n);
      repeat (n) begin
         wd_in <= 1'b1;
         @(posedge aclk);
         wd_in <= 1'b0;
         @(posedge aclk);
      end
      repeat (3) @(posedge aclk);
   endtask : wd_ticks
   task automatic watchdog_share();
      int base;
      axi_write(12'h204, 8'h00, RESP_OKAY);
      base = wd_outs;
      wd_ticks(4);
      check_val("raw wd ticks", 32'd4, wd_outs - base);
      axi_write(12'h204, 8'h09, RESP_OKAY);
      axi_write(12'h080, 8'h02, RESP_OKAY);
      wd_ticks(3);
      axi_write(12'h080, 8'h02, RESP_OKAY);
      base = wd_outs;
      wd_ticks(2);
      check_val("wd after clear", 32'd0, wd_outs - base);
      wd_ticks(2);
      check_val("wd postscaled", 32'd1, wd_outs - base);
   endtask : watchdog_share
   initial begin
      aresetn = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      arvalid = 1'b0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wd_in = 1'b0;
      mismatches = 0;
      num_checks = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      reset_values();
      unmapped();
      rate_check(8'h08, 1);
      rate_check(8'h0F, 1);
      for (int n = 0; n < 8; n++) rate_check(n[7:0], 2 << n);
      write_holdoff();
      overflow_irq();
      ext_count(1'b0, 1'b1, 8'd6);
      ext_count(1'b1, 1'b1, 8'd5);
      ext_count(1'b0, 1'b0, 8'd3);
      watchdog_share();
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
